// ===== rtl/pmrs_pkg.sv
// Package of constants and types shared by the macrocell reset and security block.
package pmrs_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CELLS     = 8;
   localparam int SIG_BITS      = 64;
   localparam int SIG_WORDS     = 2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_TIME_NS = 1000;
   localparam int RESET_CYCLES  = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Register byte addresses (word index times four)
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_CTRL     = 6'h00;
   localparam logic [5:0] ADDR_CELLCFG  = 6'h04;
   localparam logic [5:0] ADDR_PRELOAD  = 6'h08;
   localparam logic [5:0] ADDR_STATE    = 6'h0C;
   localparam logic [5:0] ADDR_SIG_LO   = 6'h10;
   localparam logic [5:0] ADDR_SIG_HI   = 6'h14;
   localparam logic [5:0] ADDR_PATTERN  = 6'h18;
   localparam logic [5:0] ADDR_STATUS   = 6'h1C;

   // ----------------------------------------------------------------
   // Control register fields, unmapped read value and pattern reset value
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SECURE   = 4;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;

   // Global operating mode.
   typedef enum logic [1:0] {PMRS_MODE_SIMPLE, PMRS_MODE_COMPLEX, PMRS_MODE_REGISTERED}
      pmrs_mode_e;

   // Per-cell function.
   typedef enum logic [1:0] {PMRS_CELL_REG, PMRS_CELL_BIDIR, PMRS_CELL_COMB, PMRS_CELL_INPUT}
      pmrs_cell_e;

endpackage

// ===== rtl/pmrs_cell_if.sv
// Interface that carries macrocell terms and configuration into the cell bank.
`timescale 1ns/1ps
`default_nettype none
interface pmrs_cell_if;
   import pmrs_pkg::*;
   logic [NUM_CELLS-1:0]   sum_term;
   logic [NUM_CELLS-1:0]   oe_term;
   logic [2*NUM_CELLS-1:0] cell_cfg;
   logic [1:0]             mode;
   logic                   oe_pin_n;
   logic                   clk_rise;
   logic                   preload;
   logic [NUM_CELLS-1:0]   preload_val;
   logic                   clear;
   logic [NUM_CELLS-1:0]   reg_state;
   logic [NUM_CELLS-1:0]   pin_o;
   logic [NUM_CELLS-1:0]   pin_oe_n;
   modport ctl  (output sum_term, oe_term, cell_cfg, mode, oe_pin_n, clk_rise, preload,
                 preload_val, clear, input reg_state, pin_o, pin_oe_n);
   modport bank (input sum_term, oe_term, cell_cfg, mode, oe_pin_n, clk_rise, preload,
                 preload_val, clear, output reg_state, pin_o, pin_oe_n);
endinterface
`default_nettype wire

// ===== rtl/pmrs_cell_bank.sv
// Bank of eight configurable macrocells with their registers and drivers.
`timescale 1ns/1ps
`default_nettype none
module pmrs_cell_bank
   import pmrs_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   pmrs_cell_if.bank cif
);

   typedef struct packed
   {
      logic [NUM_CELLS-1:0] cells_q;
   } pmrs_bank_s;

   pmrs_bank_s s_q;
   pmrs_bank_s s_d;

   // Register update: clear wins, then preload, then a clock-pin rising edge.
   always_comb
   begin
      s_d = s_q;
      if (cif.clear)
      begin
         s_d.cells_q = '0;
      end
      else if (cif.preload)
      begin
         s_d.cells_q = cif.preload_val;
      end
      else if (cif.clk_rise)
      begin
         s_d.cells_q = cif.sum_term;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Drivers per cell; enables are active low and a pin not driven reads high.
   always_comb
   begin
      for (int i = 0; i < NUM_CELLS; i++)
      begin
         cif.pin_o[i]    = 1'b1;
         cif.pin_oe_n[i] = 1'b1;
         case (pmrs_cell_e'(cif.cell_cfg[2*i +: 2]))
            PMRS_CELL_REG:
            begin
               if (pmrs_mode_e'(cif.mode) == PMRS_MODE_REGISTERED)
               begin
                  cif.pin_o[i]    = ~s_q.cells_q[i];
                  cif.pin_oe_n[i] = cif.oe_pin_n;
               end
               else
               begin
                  cif.pin_o[i]    = cif.sum_term[i];
                  cif.pin_oe_n[i] = 1'b0;
               end
            end
            PMRS_CELL_BIDIR, PMRS_CELL_COMB:
            begin
               cif.pin_o[i] = cif.sum_term[i];
               // Simple mode has no product-term enable; the cell always drives.
               if (pmrs_mode_e'(cif.mode) == PMRS_MODE_SIMPLE)
               begin
                  cif.pin_oe_n[i] = 1'b0;
               end
               else
               begin
                  cif.pin_oe_n[i] = ~cif.oe_term[i];
               end
            end
            PMRS_CELL_INPUT:
            begin
               cif.pin_oe_n[i] = 1'b1;
            end
            default:
            begin
               cif.pin_oe_n[i] = 1'b1;
            end
         endcase
      end
   end

   assign cif.reg_state = s_q.cells_q;

endmodule
`default_nettype wire

// ===== rtl/pmrs_top.sv
// Top of the macrocell reset, preload and security block with its Avalon-MM slave.
//
// Summary of operation
// - After power-up reset, every macrocell register is cleared low without a pin.
// - Registered outputs drive the inverted register, so they read high after reset.
// - Preload forces each macrocell register individually high or low.
// - A 64-bit user signature stays readable regardless of the security fuse.
// - With the security fuse set, pattern verify reads and preloads are refused.
// - Undriven inputs and bidirectional pins read high through weak pull-ups.
// - Each of eight cells is registered, bidirectional, combinatorial or input.
// - Exactly one global mode applies: registered, complex or simple.
// - In registered mode, register cells use clock pin and common enable pin.
// - Combinatorial cells in registered mode use one product-term enable, seven sum.
// - A dedicated input cell keeps its output driver permanently disabled.
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pmrs_top
   import pmrs_pkg::*;
(
   input  wire logic                 CLK,
   input  wire logic                 NRST,
   input  wire logic [5:0]           AVS_ADDRESS,
   input  wire logic                 AVS_READ,
   input  wire logic                 AVS_WRITE,
   input  wire logic [31:0]          AVS_WRITEDATA,
   input  wire logic [3:0]           AVS_BYTEENABLE,
   output logic      [31:0]          AVS_READDATA,
   output logic                      AVS_WAITREQUEST,
   input  wire logic                 PIN_CLK,
   input  wire logic                 PIN_OE_N,
   input  wire logic [NUM_CELLS-1:0] SUM_TERM,
   input  wire logic [NUM_CELLS-1:0] OE_TERM,
   input  wire logic [NUM_CELLS-1:0] IO_I,
   input  wire logic [NUM_CELLS-1:0] IO_DRIVEN,
   output logic      [NUM_CELLS-1:0] IO_O,
   output logic      [NUM_CELLS-1:0] IO_OE_N,
   output logic      [NUM_CELLS-1:0] ARRAY_FB,
   output logic                      RESET_BUSY
);

   typedef struct packed
   {
      logic [1:0]             mode_q;
      logic                   secure_q;
      logic [2*NUM_CELLS-1:0] cfg_q;
      logic [SIG_BITS-1:0]    sig_q;
      logic [31:0]            pattern_q;
      logic [15:0]            por_cnt_q;
      logic                   por_busy_q;
      logic                   preload_q;
      logic [NUM_CELLS-1:0]   preload_val_q;
      logic                   refused_q;
      logic                   ack_q;
      logic [31:0]            rdata_q;
      logic [1:0]             clk_sync_q;
      logic                   clk_prev_q;
      logic [1:0]             oe_sync_q;
      logic [2*NUM_CELLS-1:0] io_sync_q;
   } pmrs_top_s;

   pmrs_top_s s_q;
   pmrs_top_s s_d;
   logic [1:0] rst_sync_q;
   logic       rst_n;

   pmrs_cell_if cif ();

   // Reset release through two flip-flops; assert is asynchronous.
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rst_sync_q <= 2'b00;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Merge byte lanes of a write into an old word.
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  be);
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return r;
   endfunction

   logic [NUM_CELLS-1:0] pin_in;
   logic                 clk_rise;

   // Undriven pins are resolved high before synchronising.
   assign pin_in = IO_I | ~IO_DRIVEN;

   // Next-state logic: synchronisers, power-up timer, bus slave.
   always_comb
   begin
      logic [31:0] wd;
      logic        acc;
      wd = 32'h0000_0000;
      acc = (AVS_READ | AVS_WRITE) & ~s_q.ack_q;
      s_d = s_q;
      s_d.clk_sync_q = {s_q.clk_sync_q[0], PIN_CLK};
      s_d.clk_prev_q = s_q.clk_sync_q[1];
      s_d.oe_sync_q  = {s_q.oe_sync_q[0], PIN_OE_N};
      s_d.io_sync_q  = {s_q.io_sync_q[NUM_CELLS-1:0], pin_in};
      s_d.preload_q  = 1'b0;
      s_d.ack_q      = 1'b0;
      // The timer hides the clock pin while the reset interval runs.
      if (s_q.por_busy_q)
      begin
         if (s_q.por_cnt_q == 16'(RESET_CYCLES - 1))
         begin
            s_d.por_busy_q = 1'b0;
         end
         s_d.por_cnt_q = s_q.por_cnt_q + 16'h0001;
      end
      if (acc)
      begin
         s_d.ack_q   = 1'b1;
         s_d.rdata_q = UNMAPPED_READ;
         case (AVS_ADDRESS)
            ADDR_CTRL:
            begin
               s_d.rdata_q = {27'h000_0000, s_q.secure_q, 2'b00, s_q.mode_q};
               if (AVS_WRITE)
               begin
                  wd = merge_bytes(s_d.rdata_q, AVS_WRITEDATA, AVS_BYTEENABLE);
                  // Reserved encoding is ignored so one valid mode always stands.
                  if (wd[CTRL_MODE_LSB +: 2] != 2'b11)
                  begin
                     s_d.mode_q = wd[CTRL_MODE_LSB +: 2];
                  end
                  // The fuse only sets; nothing but reset clears it.
                  s_d.secure_q = s_q.secure_q | wd[CTRL_SECURE];
               end
            end
            ADDR_CELLCFG:
            begin
               s_d.rdata_q = {16'h0000, s_q.cfg_q};
               if (AVS_WRITE)
               begin
                  wd = merge_bytes(s_d.rdata_q, AVS_WRITEDATA, AVS_BYTEENABLE);
                  s_d.cfg_q = wd[2*NUM_CELLS-1:0];
               end
            end
            ADDR_PRELOAD:
            begin
               if (AVS_WRITE)
               begin
                  if (s_q.secure_q)
                  begin
                     s_d.refused_q = 1'b1;
                  end
                  else
                  begin
                     s_d.preload_q     = 1'b1;
                     s_d.preload_val_q = AVS_WRITEDATA[NUM_CELLS-1:0];
                  end
               end
            end
            ADDR_STATE:
            begin
               s_d.rdata_q = {24'h00_0000, cif.reg_state};
            end
            ADDR_SIG_LO, ADDR_SIG_HI:
            begin
               // Signature readable always, secured or not.
               s_d.rdata_q = AVS_ADDRESS[2] ? s_q.sig_q[63:32] : s_q.sig_q[31:0];
               if (AVS_WRITE && !s_q.secure_q)
               begin
                  if (AVS_ADDRESS[2])
                  begin
                     s_d.sig_q[63:32] = merge_bytes(s_q.sig_q[63:32], AVS_WRITEDATA,
                                                    AVS_BYTEENABLE);
                  end
                  else
                  begin
                     s_d.sig_q[31:0] = merge_bytes(s_q.sig_q[31:0], AVS_WRITEDATA,
                                                   AVS_BYTEENABLE);
                  end
               end
            end
            ADDR_PATTERN:
            begin
               if (s_q.secure_q)
               begin
                  s_d.rdata_q = 32'h0000_0000;
                  s_d.refused_q = s_q.refused_q | AVS_READ;
               end
               else
               begin
                  s_d.rdata_q = s_q.pattern_q;
                  if (AVS_WRITE)
                  begin
                     s_d.pattern_q = merge_bytes(s_q.pattern_q, AVS_WRITEDATA,
                                                 AVS_BYTEENABLE);
                  end
               end
            end
            ADDR_STATUS:
            begin
               s_d.rdata_q = {29'h0000_0000, s_q.refused_q, s_q.secure_q, s_q.por_busy_q};
               if (AVS_WRITE && AVS_BYTEENABLE[0] && AVS_WRITEDATA[2])
               begin
                  s_d.refused_q = 1'b0;
               end
            end
            default:
            begin
               s_d.rdata_q = UNMAPPED_READ;
            end
         endcase
      end
   end

   // All state but the reset synchroniser lives in one struct; the timer restarts on every reset.
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q            <= '0;
         s_q.mode_q     <= PMRS_MODE_REGISTERED;
         s_q.pattern_q  <= PATTERN_RESET;
         s_q.por_busy_q <= 1'b1;
         s_q.clk_sync_q <= 2'b00;
         s_q.oe_sync_q  <= 2'b11;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Clock-pin edges during the reset interval are discarded.
   assign clk_rise = s_q.clk_sync_q[1] & ~s_q.clk_prev_q & ~s_q.por_busy_q;

   assign cif.sum_term    = SUM_TERM;
   assign cif.oe_term     = OE_TERM;
   assign cif.cell_cfg    = s_q.cfg_q;
   assign cif.mode        = s_q.mode_q;
   assign cif.oe_pin_n    = s_q.oe_sync_q[1];
   assign cif.clk_rise    = clk_rise;
   assign cif.preload     = s_q.preload_q;
   assign cif.preload_val = s_q.preload_val_q;
   assign cif.clear       = s_q.por_busy_q;

   pmrs_cell_bank u_bank
   (
      .clk   (CLK),
      .rst_n (rst_n),
      .cif   (cif)
   );

   // Outputs.
   assign IO_O            = cif.pin_o;
   assign IO_OE_N         = cif.pin_oe_n;
   assign ARRAY_FB        = s_q.io_sync_q[2*NUM_CELLS-1:NUM_CELLS];
   assign RESET_BUSY      = s_q.por_busy_q;
   assign AVS_READDATA    = s_q.rdata_q;
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_q.ack_q;

endmodule
`default_nettype wire

// ===== verif/pmrs_top_props.sv
// Checker of reset, enable, pull-up and security behaviour at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module pmrs_top_props
   import pmrs_pkg::*;
(
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic [5:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        PIN_OE_N,
   input wire logic [7:0]  OE_TERM,
   input wire logic [7:0]  IO_I,
   input wire logic [7:0]  IO_DRIVEN,
   input wire logic [7:0]  IO_O,
   input wire logic [7:0]  IO_OE_N,
   input wire logic [7:0]  ARRAY_FB,
   input wire logic        RESET_BUSY
);
   // ------------------------------------------------------------
   // Shadow state
   // ------------------------------------------------------------
   logic [3:0]  up_q;
   logic [5:0]  busy_q;
   logic        sec_q;
   logic [1:0]  mode_q, mode_p;
   logic [15:0] cfg_q, cfg_p;
   logic [24:0] hi, h1, h2;
   logic [7:0]  m_in, m_reg, m_cmb;
   logic        wr_ok, ok_w, still;

   // Checks wait until configuration and pin inputs have settled, since configuration is registered and pins pass synchronisers.
   assign hi    = {PIN_OE_N, OE_TERM, IO_DRIVEN, IO_I};
   assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
   // A configuration write lands a cycle before its answer, so that pending cycle is skipped.
   assign ok_w  = (up_q == 4'hF) && (cfg_q == cfg_p) && (mode_q == mode_p)
                  && !(AVS_WRITE && (AVS_ADDRESS == ADDR_CELLCFG || AVS_ADDRESS == ADDR_CTRL));
   assign still = (hi == h1) && (h1 == h2);

   // Cell masks by configured function.
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         m_in[i]  = cfg_q[2*i+:2] == PMRS_CELL_INPUT;
         m_reg[i] = cfg_q[2*i+:2] == PMRS_CELL_REG;
         m_cmb[i] = cfg_q[2*i+:2] inside {PMRS_CELL_BIDIR, PMRS_CELL_COMB};
      end
   end

   // Accepted writes are tracked the way the register file takes them.
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         up_q   <= 4'h0;
         busy_q <= 6'h00;
         sec_q  <= 1'b0;
         mode_q <= PMRS_MODE_REGISTERED;
         mode_p <= PMRS_MODE_REGISTERED;
         cfg_q  <= 16'h0000;
         cfg_p  <= 16'h0000;
         h1     <= 25'h000_0000;
         h2     <= 25'h000_0000;
      end
      else
      begin
         up_q   <= (up_q == 4'hF) ? up_q : up_q + 4'h1;
         busy_q <= RESET_BUSY ? busy_q + 6'h01 : busy_q;
         mode_p <= mode_q;
         cfg_p  <= cfg_q;
         h1     <= hi;
         h2     <= h1;
         if (wr_ok && AVS_ADDRESS == ADDR_CELLCFG)
            cfg_q <= AVS_WRITEDATA[15:0];
         if (wr_ok && AVS_ADDRESS == ADDR_CTRL && AVS_WRITEDATA[1:0] != 2'h3)
            mode_q <= AVS_WRITEDATA[1:0];
         if (wr_ok && AVS_ADDRESS == ADDR_CTRL && AVS_WRITEDATA[CTRL_SECURE])
            sec_q <= 1'b1;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   property p_busy_len; $fell(RESET_BUSY) |-> busy_q inside {[RESET_CYCLES:RESET_CYCLES+2]};
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("reset interval length wrong");
   property p_clear; RESET_BUSY |-> IO_O == 8'hFF;
   endproperty
   a_clear: assert property (p_clear) else $error("registers not clear in reset");
   property p_high; $fell(RESET_BUSY) |-> (IO_O == 8'hFF) [*2];
   endproperty
   a_high: assert property (p_high) else $error("outputs not high after reset");
   property p_in_off; ok_w |-> (IO_OE_N & m_in) == m_in;
   endproperty
   a_in_off: assert property (p_in_off) else $error("input cell driver on");
   property p_reg_oe; ok_w && mode_q == PMRS_MODE_REGISTERED && still
      |-> (IO_OE_N & m_reg) == ({8{PIN_OE_N}} & m_reg);
   endproperty
   a_reg_oe: assert property (p_reg_oe) else $error("register cell enable wrong");
   property p_cmb_oe; ok_w && mode_q == PMRS_MODE_REGISTERED && still
      |-> (IO_OE_N & m_cmb) == (~OE_TERM & m_cmb);
   endproperty
   a_cmb_oe: assert property (p_cmb_oe) else $error("term enable wrong");
   property p_pullup; up_q == 4'hF && still |-> ((ARRAY_FB ^ (IO_I | ~IO_DRIVEN))
      & IO_OE_N & $past(IO_OE_N) & $past(IO_OE_N, 2)) == 8'h00;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pin feedback wrong");
   property p_pat_ref; sec_q && AVS_READ && AVS_ADDRESS == ADDR_PATTERN && !AVS_WAITREQUEST
      |-> AVS_READDATA == 32'h0000_0000;
   endproperty
   a_pat_ref: assert property (p_pat_ref) else $error("pattern read while secure");
endmodule

bind pmrs_top pmrs_top_props u_props (.CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_OE_N(PIN_OE_N),
   .OE_TERM(OE_TERM), .IO_I(IO_I), .IO_DRIVEN(IO_DRIVEN), .IO_O(IO_O), .IO_OE_N(IO_OE_N),
   .ARRAY_FB(ARRAY_FB), .RESET_BUSY(RESET_BUSY));
`default_nettype wire

// ===== verif/pmrs_board_model.sv
// Board-side model that drives the clock pin and resolves the pin levels.
`timescale 1ns/1ps
`default_nettype none
module pmrs_board_model
(
   input  wire logic       clk,
   input  wire logic       busy,
   input  wire logic       go,
   input  wire logic [7:0] drv_en,
   input  wire logic [7:0] drv_val,
   input  wire logic [7:0] dev_o,
   input  wire logic [7:0] dev_oe_n,
   output logic            pin_clk,
   output logic [7:0]      pin_lvl,
   output logic [7:0]      driven
);
   logic [3:0] cnt_q = 4'h0;

   // The clock pin stays low through reset; a pulse lasts long enough to pass the synchroniser.
   always_ff @(posedge clk)
   begin
      if (busy !== 1'b0)
         cnt_q <= 4'h0;
      else if (go && cnt_q == 4'h0)
         cnt_q <= 4'h1;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q + 4'h1;
   end

   // Two settle cycles pass before the rising edge, so the terms meet setup.
   assign pin_clk = (cnt_q >= 4'h3) && (cnt_q <= 4'h6);

   // The device wins when it drives, then the board; a pin that nobody drives floats and is
   // shown low here, so that only the device's own pull-up can lift it.
   assign pin_lvl = (~dev_oe_n & dev_o) | (dev_oe_n & drv_en & drv_val);
   assign driven  = drv_en;
endmodule
`default_nettype wire

// ===== verif/test_pmrs_top.sv
// Self-checking testbench of the macrocell reset, preload and security block.
`timescale 1ns/1ps
`default_nettype none
module test_pmrs_top
   import pmrs_pkg::*;
;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
   $display("[ERR] %s expected %h seen %h", n, e, s); end end
   typedef struct packed {logic w; logic [5:0] a; logic [31:0] d; logic [31:0] e;} pmrs_row_s;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   localparam pmrs_row_s ROWS [16] = '{
      '{1'b1, ADDR_CELLCFG, ZERO, ZERO}, '{1'b1, ADDR_PRELOAD, 32'h0000_00A5, ZERO},
      '{1'b0, ADDR_STATE, ZERO, 32'h0000_00A5}, '{1'b1, ADDR_SIG_LO, 32'h1234_5678, ZERO},
      '{1'b1, ADDR_SIG_HI, 32'h9ABC_DEF0, ZERO}, '{1'b0, ADDR_SIG_LO, ZERO, 32'h1234_5678},
      '{1'b0, ADDR_SIG_HI, ZERO, 32'h9ABC_DEF0}, '{1'b1, ADDR_PATTERN, 32'h0F0F_00FF, ZERO},
      '{1'b0, ADDR_PATTERN, ZERO, 32'h0F0F_00FF}, '{1'b1, 6'h20, 32'hFFFF_FFFF, ZERO},
      '{1'b0, 6'h20, ZERO, UNMAPPED_READ}, '{1'b0, ADDR_CTRL, ZERO, 32'h0000_0002},
      '{1'b1, ADDR_CTRL, 32'h0000_0001, ZERO}, '{1'b1, ADDR_CTRL, 32'h0000_0003, ZERO},
      '{1'b0, ADDR_CTRL, ZERO, 32'h0000_0001}, '{1'b1, ADDR_CTRL, 32'h0000_0002, ZERO}};

   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [5:0]  addr = 6'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, q;
   logic        waitreq, pin_clk, busy;
   logic        oe_n = 1'b1;
   logic        go = 1'b0;
   logic [7:0]  sum = 8'h00;
   logic [7:0]  oe_t = 8'h00;
   logic [7:0]  drv_en = 8'h00;
   logic [7:0]  io_i, io_drv, io_o, io_oe_n, fb;
   int          num_errors = 0;
   int          tests_run = 0;

   always #25 clk = ~clk;

   pmrs_top DUT (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .PIN_CLK(pin_clk), .PIN_OE_N(oe_n), .SUM_TERM(sum),
      .OE_TERM(oe_t), .IO_I(io_i), .IO_DRIVEN(io_drv), .IO_O(io_o), .IO_OE_N(io_oe_n),
      .ARRAY_FB(fb), .RESET_BUSY(busy));
   pmrs_board_model u_board (.clk(clk), .busy(busy), .go(go), .drv_en(drv_en),
      .drv_val(8'h00), .dev_o(io_o), .dev_oe_n(io_oe_n), .pin_clk(pin_clk),
      .pin_lvl(io_i), .driven(io_drv));

   // Prints the counts and the verdict, then ends the run.
   task wrap_up;
      $display("tests %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One Avalon transfer; the request is held until waitrequest is seen low at a rising edge.
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      addr  <= a;
      wr    <= w;
      rd    <= !w;
      wdata <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (waitreq !== 1'b0 && n < 20);
      if (waitreq !== 1'b0)
         `CHK("waitrequest", 1'b0, waitreq)
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // Waits, with a bound, for the power-up interval to end.
   task wait_ready;
      int n;
      n = 0;
      repeat (3) @(negedge clk);
      while (busy !== 1'b0 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   // Main sequence: reset, table rows, then the awkward cases.
   initial
   begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK("busy", 1'b1, busy)
      wait_ready;
      `CHK("io_o", 8'hFF, io_o)
      bus(1'b0, ADDR_STATE, ZERO);
      `CHK("state", 32'h0000_0000, q)
      $display("test reset done");
      for (int i = 0; i < 16; i++)
      begin
         bus(ROWS[i].w, ROWS[i].a, ROWS[i].d);
         if (!ROWS[i].w)
            `CHK("row", ROWS[i].e, q)
      end
      $display("test rows done");
      sum  <= 8'h3C;
      oe_n <= 1'b0;
      go   <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (14) @(posedge clk);
      bus(1'b0, ADDR_STATE, ZERO);
      `CHK("capture", 32'h0000_003C, q)
      `CHK("io_o", 8'hC3, io_o)
      `CHK("io_oe_n", 8'h00, io_oe_n)
      $display("test capture done");
      bus(1'b1, ADDR_PRELOAD, 32'h0000_0081);
      bus(1'b1, ADDR_CTRL, 32'h0000_0012);
      bus(1'b1, ADDR_PRELOAD, 32'h0000_00FF);
      bus(1'b0, ADDR_STATE, ZERO);
      `CHK("locked state", 32'h0000_0081, q)
      bus(1'b0, ADDR_STATUS, ZERO);
      `CHK("status", 2'b11, q[2:1])
      bus(1'b0, ADDR_PATTERN, ZERO);
      `CHK("pattern", 32'h0000_0000, q)
      bus(1'b0, ADDR_SIG_HI, ZERO);
      `CHK("signature", 32'h9ABC_DEF0, q)
      bus(1'b1, ADDR_STATUS, 32'h0000_0004);
      bus(1'b0, ADDR_STATUS, ZERO);
      `CHK("refused", 1'b0, q[2])
      $display("test security done");
      bus(1'b1, ADDR_CELLCFG, 32'h0000_E4E4);
      oe_t   <= 8'h22;
      drv_en <= 8'h08;
      repeat (5) @(negedge clk);
      `CHK("cell enables", 8'hCC, io_oe_n)
      `CHK("feedback", 2'b10, {fb[7], fb[3]})
      $display("test cells done");
      bus(1'b1, ADDR_CTRL, 32'h0000_0000);
      `CHK("simple enables", 8'h88, io_oe_n)
      `CHK("simple outputs", 8'hBC, io_o)
      bus(1'b1, ADDR_CTRL, 32'h0000_0001);
      `CHK("complex enables", 8'hCC, io_oe_n)
      $display("test modes done");
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      wait_ready;
      `CHK("io_o", 8'hFF, io_o)
      bus(1'b0, ADDR_STATUS, ZERO);
      `CHK("status", 32'h0000_0000, q)
      $display("test second reset done");
      wrap_up;
   end

   // Watchdog over the expected length of the run.
   initial
   begin
      repeat (5000) @(posedge clk);
      `CHK("watchdog", 1'b1, 1'b0)
      wrap_up;
   end
endmodule
`default_nettype wire
